// file: logic/ccr_pkg.sv
package ccr_pkg;

  // Attribute-space register addresses (byte addresses on the card bus)
  localparam logic [10:0] ADDR_OPTION = 11'h200;
  localparam logic [10:0] ADDR_STATUS = 11'h202;
  localparam logic [10:0] ADDR_PIN    = 11'h204;
  localparam logic [10:0] ADDR_SOCKET = 11'h206;

  // Option register fields
  localparam int OPT_SRST_BIT  = 7;
  localparam int OPT_LEVEL_BIT = 6;
  localparam int OPT_MAP_MSB   = 5;

  // Status register fields
  localparam int STS_CHG_BIT   = 7;
  localparam int STS_SIGEN_BIT = 6;
  localparam int STS_BYTE_BIT  = 5;
  localparam int STS_PWD_BIT   = 2;
  localparam int STS_IRQ_BIT   = 1;

  // Pin state mirror fields
  localparam int PIN_RCHG_BIT  = 5;
  localparam int PIN_RLVL_BIT  = 1;
  localparam logic [7:0] PIN_FIXED = 8'h0c;

  // Socket and copy field
  localparam int SOCK_COPY_BIT = 4;

  // Reset values
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET    = 8'h0c;
  localparam logic [7:0] SOCKET_RESET = 8'h00;

  // Map select encodings
  localparam logic [5:0] MAP_MEMORY     = 6'h00;
  localparam logic [5:0] MAP_CONTIG_IO  = 6'h01;
  localparam logic [5:0] MAP_PRIMARY_IO = 6'h02;

  // Power-state settling time and automatic idle power-down time
  localparam int PWR_SETTLE_NS   = 1000;
  localparam int AUTO_IDLE_NS    = 10000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PWR_SETTLE_CYC  = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUTO_IDLE_CYC   = AUTO_IDLE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    CCR_PWR_ACTIVE  = 2'b00,
    CCR_PWR_TO_DOWN = 2'b01,
    CCR_PWR_SLEEP   = 2'b11,
    CCR_PWR_TO_UP   = 2'b10
  } ccr_pwr_t;

  typedef struct packed {
    logic       srst;
    logic       level_irq_select;
    logic [5:0] map_select;
    logic       change_signal_enable;
    logic       host_byte_bus_only;
    logic       power_down_request;
    logic       ready_changed;
    logic       ready_mask;
    logic [7:0] socket;
    ccr_pwr_t   pwr;
    logic [9:0] pwr_cnt;
    logic [9:0] idle_cnt;
    logic       ready_s1;
    logic       ready_s2;
    logic       ready_s3;
    logic       ready_prev;
    logic       irq_pending;
    logic       status_change_n;
    logic [7:0] rdata;
    logic       rvalid;
    logic       soft_reset;
    logic       card_reset;
    logic       irq_pulse;
    logic       sleep;
  } ccr_state_t;

endpackage

// file: logic/ccr_card_config.sv
module ccr_card_config #(
  parameter int PWR_SETTLE = ccr_pkg::PWR_SETTLE_CYC,
  parameter int AUTO_IDLE  = ccr_pkg::AUTO_IDLE_CYC
) (
  // Clock and card hard reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // Attribute register access, one-cycle strobes
  input  wire logic        reg_sel_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic [10:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        true_ide_i,
  // Card status inputs
  input  wire logic        ready_pin_i,
  input  wire logic        int_req_i,
  input  wire logic        irq_disable_bit_i,
  input  wire logic        io_mode_i,
  input  wire logic        command_i,
  // Register read data and card controls
  output logic [7:0]       rdata_o,
  output logic             rvalid_o,
  output logic             soft_reset_o,
  output logic             card_reset_o,
  output logic [5:0]       map_select_o,
  output logic             level_irq_select_o,
  output logic             irq_pulse_o,
  output logic             status_change_pin_o,
  output logic             sleep_o,
  output logic             host_byte_bus_only_o,
  output logic [7:0]       socket_copy_id_o
);

  ccr_pkg::ccr_state_t s;
  ccr_pkg::ccr_state_t next_s;

  logic       acc;
  logic       wr_opt;
  logic       wr_sts;
  logic       wr_pin;
  logic       wr_sock;
  logic       ready_lvl;
  logic       irq_req;
  logic [7:0] opt_v;
  logic [7:0] sts_v;
  logic [7:0] pin_v;

  assign acc     = reg_sel_i && !true_ide_i;
  assign wr_opt  = acc && wr_i && addr_i == ccr_pkg::ADDR_OPTION;
  assign wr_sts  = acc && wr_i && addr_i == ccr_pkg::ADDR_STATUS;
  assign wr_pin  = acc && wr_i && addr_i == ccr_pkg::ADDR_PIN;
  assign wr_sock = acc && wr_i && addr_i == ccr_pkg::ADDR_SOCKET;
  assign irq_req = int_req_i && !irq_disable_bit_i;

  // Ready shows busy while a power transition is under way
  assign ready_lvl = s.ready_s2 && s.ready_s3 &&
                     (s.pwr == ccr_pkg::CCR_PWR_ACTIVE || s.pwr == ccr_pkg::CCR_PWR_SLEEP);

  always_comb begin
    opt_v = {s.srst, s.level_irq_select, s.map_select};
    sts_v = ccr_pkg::STATUS_RESET;
    sts_v[ccr_pkg::STS_CHG_BIT]   = s.ready_changed;
    sts_v[ccr_pkg::STS_SIGEN_BIT] = s.change_signal_enable;
    sts_v[ccr_pkg::STS_BYTE_BIT]  = s.host_byte_bus_only;
    sts_v[ccr_pkg::STS_PWD_BIT]   = s.power_down_request;
    sts_v[ccr_pkg::STS_IRQ_BIT]   = s.irq_pending;
    pin_v = ccr_pkg::PIN_FIXED;
    pin_v[ccr_pkg::PIN_RCHG_BIT] = s.ready_changed;
    pin_v[ccr_pkg::PIN_RLVL_BIT] = s.ready_prev;
  end

  always_comb begin
    next_s = s;
    next_s.ready_s1 = ready_pin_i;
    next_s.ready_s2 = s.ready_s1;
    next_s.ready_s3 = s.ready_s2;
    next_s.ready_prev = ready_lvl;
    next_s.rvalid = 1'b0;
    next_s.soft_reset = 1'b0;
    next_s.irq_pulse = 1'b0;

    // Read mux, unmapped reads give zero
    if (acc && rd_i) begin
      next_s.rvalid = 1'b1;
      unique case (addr_i)
        ccr_pkg::ADDR_OPTION: next_s.rdata = opt_v;
        ccr_pkg::ADDR_STATUS: next_s.rdata = sts_v;
        ccr_pkg::ADDR_PIN:    next_s.rdata = pin_v;
        ccr_pkg::ADDR_SOCKET: next_s.rdata = s.socket;
        default:              next_s.rdata = 8'h00;
      endcase
    end

    if (wr_sts) begin
      next_s.change_signal_enable = wdata_i[ccr_pkg::STS_SIGEN_BIT];
      next_s.host_byte_bus_only   = wdata_i[ccr_pkg::STS_BYTE_BIT];
      next_s.power_down_request   = wdata_i[ccr_pkg::STS_PWD_BIT];
      if (wdata_i[ccr_pkg::STS_PWD_BIT] != s.power_down_request) begin
        next_s.pwr     = wdata_i[ccr_pkg::STS_PWD_BIT] ? ccr_pkg::CCR_PWR_TO_DOWN
                                                       : ccr_pkg::CCR_PWR_TO_UP;
        next_s.pwr_cnt = '0;
      end
    end
    if (wr_sock) begin
      next_s.socket = '0;
      next_s.socket[ccr_pkg::SOCK_COPY_BIT] = wdata_i[ccr_pkg::SOCK_COPY_BIT];
    end

    // Host write to ready-changed, then hardware set wins
    if (wr_pin) begin
      next_s.ready_changed = wdata_i[ccr_pkg::PIN_RCHG_BIT];
      next_s.ready_mask    = wdata_i[ccr_pkg::PIN_RLVL_BIT];
    end
    if (ready_lvl != s.ready_prev && !s.ready_mask) begin
      next_s.ready_changed = 1'b1;
    end

    // Power state sequencing
    unique case (s.pwr)
      ccr_pkg::CCR_PWR_ACTIVE: begin
        if (command_i || acc) begin
          next_s.idle_cnt = '0;
        end else if (32'(s.idle_cnt) >= AUTO_IDLE - 1) begin
          next_s.pwr     = ccr_pkg::CCR_PWR_TO_DOWN;
          next_s.pwr_cnt = '0;
          next_s.idle_cnt = '0;
        end else begin
          next_s.idle_cnt = s.idle_cnt + 10'h001;
        end
      end
      ccr_pkg::CCR_PWR_TO_DOWN, ccr_pkg::CCR_PWR_TO_UP: begin
        if (32'(s.pwr_cnt) >= PWR_SETTLE - 1) begin
          next_s.pwr = (s.pwr == ccr_pkg::CCR_PWR_TO_DOWN) ? ccr_pkg::CCR_PWR_SLEEP
                                                           : ccr_pkg::CCR_PWR_ACTIVE;
        end else begin
          next_s.pwr_cnt = s.pwr_cnt + 10'h001;
        end
      end
      ccr_pkg::CCR_PWR_SLEEP: begin
        if (command_i && !s.power_down_request) begin
          next_s.pwr     = ccr_pkg::CCR_PWR_TO_UP;
          next_s.pwr_cnt = '0;
        end
      end
    endcase
    if (wr_sts && wdata_i[ccr_pkg::STS_PWD_BIT] != s.power_down_request) begin
      next_s.idle_cnt = '0;
    end
    next_s.sleep = (next_s.pwr == ccr_pkg::CCR_PWR_SLEEP);

    // Interrupt pending and its signalling style
    next_s.irq_pending = irq_req;
    // Level mode follows pending, pulse mode marks its rise
    next_s.irq_pulse   = s.level_irq_select ? irq_req : irq_req && !s.irq_pending;
    next_s.status_change_n = !(io_mode_i && s.change_signal_enable &&
                               next_s.ready_changed);

    // Option write, soft reset clears state like a hard reset but keeps the socket register, the ready synchronisers and srst set
    if (wr_opt) begin
      next_s.level_irq_select = wdata_i[ccr_pkg::OPT_LEVEL_BIT];
      next_s.map_select       = wdata_i[ccr_pkg::OPT_MAP_MSB:0];
      next_s.srst             = wdata_i[ccr_pkg::OPT_SRST_BIT];
      if (wdata_i[ccr_pkg::OPT_SRST_BIT]) begin
        next_s = '0;
        next_s.srst            = 1'b1;
        next_s.status_change_n = 1'b1;
        next_s.soft_reset      = 1'b1;
        next_s.ready_s1        = s.ready_s1;
        next_s.ready_s2        = s.ready_s2;
        next_s.ready_s3        = s.ready_s3;
        next_s.socket          = s.socket;
        next_s.map_select      = ccr_pkg::MAP_MEMORY;
      end
    end
    // Internal initialisation runs while the soft reset bit is held
    next_s.card_reset = next_s.srst;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s                      <= '0;
      s.srst                 <= ccr_pkg::OPTION_RESET[ccr_pkg::OPT_SRST_BIT];
      s.level_irq_select     <= ccr_pkg::OPTION_RESET[ccr_pkg::OPT_LEVEL_BIT];
      s.map_select           <= ccr_pkg::OPTION_RESET[ccr_pkg::OPT_MAP_MSB:0];
      s.change_signal_enable <= ccr_pkg::STATUS_RESET[ccr_pkg::STS_SIGEN_BIT];
      s.host_byte_bus_only   <= ccr_pkg::STATUS_RESET[ccr_pkg::STS_BYTE_BIT];
      s.power_down_request   <= ccr_pkg::STATUS_RESET[ccr_pkg::STS_PWD_BIT];
      s.ready_changed        <= ccr_pkg::PIN_RESET[ccr_pkg::PIN_RCHG_BIT];
      s.ready_prev           <= ccr_pkg::PIN_RESET[ccr_pkg::PIN_RLVL_BIT];
      s.socket               <= ccr_pkg::SOCKET_RESET;
      s.pwr                  <= ccr_pkg::CCR_PWR_ACTIVE;
      s.status_change_n      <= 1'b1;
      s.card_reset           <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o              = s.rdata;
  assign rvalid_o             = s.rvalid;
  assign soft_reset_o         = s.soft_reset;
  assign card_reset_o         = s.card_reset;
  assign map_select_o         = s.map_select;
  assign level_irq_select_o   = s.level_irq_select;
  assign irq_pulse_o          = s.irq_pulse;
  assign status_change_pin_o  = s.status_change_n;
  assign sleep_o              = s.sleep;
  assign host_byte_bus_only_o = s.host_byte_bus_only;
  assign socket_copy_id_o     = s.socket;

endmodule

// file: sim/ccr_card_config_asserts.sv
module ccr_card_config_asserts #(
  parameter int PWR_SETTLE = ccr_pkg::PWR_SETTLE_CYC
) (
  // Clock, reset, access and card status inputs
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  input wire logic        reg_sel_i,
  input wire logic        rd_i,
  input wire logic        wr_i,
  input wire logic        true_ide_i,
  input wire logic [10:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        io_mode_i,
  input wire logic        irq_disable_bit_i,
  // Design outputs
  input wire logic        rvalid_o,
  input wire logic        card_reset_o,
  input wire logic [5:0]  map_select_o,
  input wire logic        level_irq_select_o,
  input wire logic        irq_pulse_o,
  input wire logic        status_change_pin_o,
  input wire logic        sleep_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLP_MAX = 2 * PWR_SETTLE + 6;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_opt_wr;
    reg_sel_i && wr_i && !true_ide_i && addr_i == ccr_pkg::ADDR_OPTION;
  endsequence
  sequence s_sts_wr;
    reg_sel_i && wr_i && !true_ide_i && addr_i == ccr_pkg::ADDR_STATUS;
  endsequence
  a_read_answer: assert property (reg_sel_i && rd_i && !true_ide_i |=> rvalid_o)
    else $error("read not answered");
  a_ide_refused: assert property (true_ide_i |=> !rvalid_o)
    else $error("read answered in ide mode");
  a_srst_hold: assert property (s_opt_wr ##0 wdata_i[7] |=> card_reset_o && map_select_o == 6'h00)
    else $error("soft reset not applied");
  a_map_write: assert property (s_opt_wr ##0 !wdata_i[7] |=> map_select_o == $past(wdata_i[5:0])
    && level_irq_select_o == $past(wdata_i[6])) else $error("option fields not stored");
  a_reset_map: assert property ($fell(rst_i) |-> map_select_o == 6'h00 && !level_irq_select_o)
    else $error("option not cleared by reset");
  a_pin_idle: assert property (!io_mode_i [*2] |-> status_change_pin_o)
    else $error("status pin low outside io mode");
  a_sleep_go: assert property (s_sts_wr ##0 wdata_i[2] && !sleep_o |-> ##[1:SLP_MAX] sleep_o)
    else $error("sleep not reached");
  a_pulse_one: assert property (!level_irq_select_o && irq_pulse_o |=> !irq_pulse_o || level_irq_select_o)
    else $error("pulse mode interrupt too long");
  a_irq_masked: assert property (irq_disable_bit_i [*3] ##0 level_irq_select_o |-> !irq_pulse_o)
    else $error("interrupt shown while disabled");
endmodule

bind ccr_card_config ccr_card_config_asserts #(.PWR_SETTLE(PWR_SETTLE)) u_chk (.*);

// file: sim/ccr_host_model.sv
module ccr_host_model (
  // Clock
  input  wire logic        clk_i,
  // Attribute bus
  output logic             sel_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic [10:0]      addr_o,
  output logic [7:0]       wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_o = 1'b0;
    rd_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 11'h000;
    wdata_o = 8'h00;
  end
  // Same access order after every reset
  task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {sel_o, rd_o, wr_o, addr_o, wdata_o} = {1'b1, !w, w, a, d};
    @(negedge clk_i);
    {sel_o, rd_o, wr_o, addr_o, wdata_o} = {3'b000, ~a, ~d};
  endtask
endmodule

// file: sim/ccr_card_config_tb_top.sv
module ccr_card_config_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SETTLE = 4;
  localparam int IDLE   = 40;
  logic        core_clk_i, rst_i, true_ide_i, ready_pin_i, int_req_i, irq_dis, io_mode_i, command_i;
  logic        sel, rd_s, wr_s, rvalid, card_rst, irq_pulse, chg_pin_n, sleep, byte_only, soft_rst, lvl_sel;
  logic [10:0] addr;
  logic [5:0]  map_sel;
  logic [7:0]  wdata, rdata, r, sock;
  logic [7:0]  exp_q[$];
  int          err_total, n_compared;
  ccr_host_model host (.clk_i(core_clk_i), .sel_o(sel), .rd_o(rd_s), .wr_o(wr_s), .addr_o(addr), .wdata_o(wdata));
  ccr_card_config #(.PWR_SETTLE(SETTLE), .AUTO_IDLE(IDLE)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_sel_i(sel), .rd_i(rd_s), .wr_i(wr_s), .addr_i(addr),
    .wdata_i(wdata), .true_ide_i(true_ide_i), .ready_pin_i(ready_pin_i), .int_req_i(int_req_i),
    .irq_disable_bit_i(irq_dis), .io_mode_i(io_mode_i), .command_i(command_i), .rdata_o(rdata),
    .rvalid_o(rvalid), .soft_reset_o(soft_rst), .card_reset_o(card_rst), .map_select_o(map_sel),
    .level_irq_select_o(lvl_sel), .irq_pulse_o(irq_pulse), .status_change_pin_o(chg_pin_n), .sleep_o(sleep),
    .host_byte_bus_only_o(byte_only), .socket_copy_id_o(sock));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.acc(1'b0, a, 8'h00);
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic results;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Unexpected answers meet an unknown expectation
  always @(negedge core_clk_i) if (rvalid === 1'b1) chk(rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #50000;
    err_total++;
    results();
  end
  initial begin
    {rst_i, true_ide_i, ready_pin_i, int_req_i, irq_dis, io_mode_i, command_i} = 7'b1000010;
    void'($urandom(41674));
    w(12);
    rst_i = 1'b0;
    rd(11'h200, 8'h00);
    rd(11'h202, 8'h00);
    rd(11'h204, 8'h0c);
    rd(11'h208, 8'h00);
    r = $urandom;
    host.acc(1'b1, 11'h206, r);
    rd(11'h206, r & 8'h10);
    chk(sock, r & 8'h10);
    for (int m = 0; m < 3; m++) begin
      r = {1'b0, 1'($urandom), 6'(m)};
      host.acc(1'b1, 11'h200, r);
      rd(11'h200, r);
    end
    chk(8'(map_sel), 8'h02);
    chk(8'(lvl_sel), 8'(r[6]));
    host.acc(1'b1, 11'h202, 8'hfb);
    rd(11'h202, 8'h60);
    chk(8'(byte_only), 8'h01);
    ready_pin_i = 1'b1;
    w(8);
    rd(11'h204, 8'h2e);
    rd(11'h202, 8'he0);
    chk(8'(chg_pin_n), 8'h00);
    io_mode_i = 1'b0;
    w(2);
    chk(8'(chg_pin_n), 8'h01);
    io_mode_i = 1'b1;
    host.acc(1'b1, 11'h204, 8'h02);
    rd(11'h204, 8'h0e);
    chk(8'(chg_pin_n), 8'h01);
    ready_pin_i = 1'b0;
    w(8);
    rd(11'h204, 8'h0c);
    ready_pin_i = 1'b1;
    w(8);
    host.acc(1'b1, 11'h202, 8'h64);
    rd(11'h204, 8'h0c);
    w(SETTLE + 6);
    chk(8'(sleep), 8'h01);
    rd(11'h204, 8'h0e);
    host.acc(1'b1, 11'h202, 8'h60);
    w(SETTLE + 6);
    chk(8'(sleep), 8'h00);
    w(IDLE + SETTLE + 10);
    chk(8'(sleep), 8'h01);
    command_i = 1'b1;
    w(1);
    command_i = 1'b0;
    w(SETTLE + 8);
    chk(8'(sleep), 8'h00);
    host.acc(1'b1, 11'h200, 8'h40);
    int_req_i = 1'b1;
    w(4);
    chk(8'(irq_pulse), 8'h01);
    chk(8'(lvl_sel), 8'h01);
    rd(11'h202, 8'h62);
    irq_dis = 1'b1;
    w(4);
    rd(11'h202, 8'h60);
    {irq_dis, int_req_i} = 2'b00;
    host.acc(1'b1, 11'h200, 8'h00);
    int_req_i = 1'b1;
    w(1);
    chk(8'(irq_pulse), 8'h01);
    w(1);
    chk(8'(irq_pulse), 8'h00);
    w(2);
    host.acc(1'b1, 11'h200, 8'h82);
    chk(8'(card_rst), 8'h01);
    chk(8'(soft_rst), 8'h01);
    rd(11'h200, 8'h80);
    rd(11'h202, 8'h82);
    chk(8'(soft_rst), 8'h00);
    w(1);
    rst_i = 1'b1;
    w(1);
    chk(8'(card_rst), 8'h01);
    w(1);
    rst_i = 1'b0;
    rd(11'h200, 8'h00);
    chk(8'(card_rst), 8'h00);
    host.acc(1'b1, 11'h200, 8'h00);
    chk(8'(card_rst), 8'h00);
    true_ide_i = 1'b1;
    host.acc(1'b1, 11'h200, 8'h41);
    host.acc(1'b0, 11'h200, 8'h00);
    true_ide_i = 1'b0;
    rd(11'h200, 8'h00);
    w(4);
    chk(8'(exp_q.size()), 8'h00);
    results();
  end
endmodule
